/* File: common/mfc_pkg.sv */
// shared constants and types of the modem frame control block
package mfc_pkg;
    // register indices on the serial configuration port
    localparam logic [5:0] MFC_ADDR_CTRL_A = 6'h11;
    localparam logic [5:0] MFC_ADDR_CTRL_B = 6'h12;
    localparam logic [5:0] MFC_ADDR_STRENGTH = 6'h13;
    // modem_control_a fields
    localparam int MFC_A_RSV_FRAME = 13;
    localparam int MFC_A_COORD = 12;
    localparam int MFC_A_ADR_EN = 11;
    localparam int MFC_A_HYST_LSB = 8;
    localparam int MFC_A_SEL_LSB = 6;
    localparam int MFC_A_AUTO_CHECKSUM_ENABLE = 5;
    localparam int MFC_A_AUTO_ACKNOWLEDGE_ENABLE = 4;
    localparam int MFC_A_PRE_LSB = 0;
    // modem_control_b fields
    localparam int MFC_B_CORR_LSB = 6;
    localparam int MFC_B_AVG = 5;
    localparam int MFC_B_MODUL = 4;
    localparam int MFC_B_TXSRC_LSB = 2;
    localparam int MFC_B_RXSNK_LSB = 0;
    // reset values and writable masks
    localparam logic [15:0] MFC_CTRL_A_RESET = 16'h0ae2;
    localparam logic [15:0] MFC_CTRL_A_MASK = 16'h3fff;
    localparam logic [15:0] MFC_CTRL_B_RESET = 16'h0000;
    localparam logic [15:0] MFC_CTRL_B_MASK = 16'h07ff;
    localparam logic [7:0] MFC_THR_RESET = 8'he0;
    localparam logic [7:0] MFC_STRENGTH_INVALID = 8'h80;
    // counts in symbol periods
    localparam logic [3:0] MFC_ACK_SYMBOLS = 4'hc;
    localparam logic [2:0] MFC_AVG_LAST = 3'h7;
    // serial port bit counts
    localparam logic [4:0] MFC_SPI_ADDR_LAST = 5'h07;
    localparam logic [4:0] MFC_SPI_WORD_LAST = 5'h17;
    // checksum, bit-reversed form of x^16+x^12+x^5+1
    localparam logic [15:0] MFC_CRC_POLY = 16'h8408;
    localparam logic [15:0] MFC_CRC_INIT = 16'h0000;
    localparam logic [7:0] MFC_PRBS_FEED = 8'hff;
    // modes
    localparam logic [1:0] MFC_SRC_BUFFER = 2'h0;
    localparam logic [1:0] MFC_SRC_SERIAL = 2'h1;
    localparam logic [1:0] MFC_SRC_LOOP = 2'h2;
    localparam logic [1:0] MFC_SRC_PRBS = 2'h3;
    localparam logic [1:0] MFC_SNK_BUFFER = 2'h0;
    localparam logic [1:0] MFC_SNK_PINS = 2'h1;
    localparam logic [1:0] MFC_SNK_LOOP = 2'h2;
    localparam logic [1:0] MFC_SEL_LEVEL = 2'h1;
    localparam logic [1:0] MFC_SEL_RXDATA = 2'h2;
    localparam logic [1:0] MFC_SEL_BOTH = 2'h3;
    typedef enum logic [2:0] {
        MFC_TX_IDLE = 3'b000,
        MFC_TX_PRE = 3'b001,
        MFC_TX_SYNC = 3'b010,
        MFC_TX_DATA = 3'b011,
        MFC_TX_CRC_LO = 3'b100,
        MFC_TX_CRC_HI = 3'b101
    } mfc_tx_state_t;
endpackage : mfc_pkg

/* File: src/mfc_crc16.sv */
// byte-wide checksum engine, least significant bit first
`timescale 1ns/1ps
module mfc_crc16
    import mfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic update,
    input wire logic [7:0] data,
    output logic [15:0] crc
);
    logic [15:0] crc_next;
    logic fb;

    always_comb
    begin
        crc_next = crc;
        fb = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            fb = crc_next[0] ^ data[i];
            crc_next = {1'b0, crc_next[15:1]} ^ (fb ? MFC_CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            crc <= MFC_CRC_INIT;
        else if (ce && clear)
            crc <= MFC_CRC_INIT;
        else if (ce && update)
            crc <= crc_next;
    end
endmodule : mfc_crc16

/* File: src/mfc_modem_frame_control.sv */
// modem control registers, frame filter, channel assessment, tx/rx paths
`timescale 1ns/1ps
// How it works
// - filtering on: reserved frame types rejected
// - reserved acceptance bit: reserved types always accepted
// - filtering off accepts all frames
// - coordinator bit decides frames without destination
// - three-bit hysteresis field, reset two
// - level mode: clear below threshold minus hysteresis
// - data mode: clear unless valid data
// - both mode: level and no data
// - transmitter appends checksum after last byte
// - receiver checks checksum of each frame
// - acknowledge twelve symbols after good frame
// - preamble is field plus one zero bytes
// - averaging bit zero freezes offset filter on preamble match
// - modulation bit selects reversed phase
// - source zero buffer, one serial endless
// - source two loops buffer ignoring underflow
// - source three sends checksum pseudo-random data
// - sink zero buffer, one pins, three reserved
// - sink two loops buffer ignoring overflow
// - signed threshold resets to minus thirty-two
// - strength averaged eight symbols, invalid minus 128
module mfc_modem_frame_control
    import mfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_si,
    output logic spi_so,
    input wire logic symbol_tick,
    input wire logic rx_on,
    input wire logic [7:0] rssi_sample,
    input wire logic rx_valid_data,
    input wire logic preamble_match,
    input wire logic rx_frame_start,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte,
    input wire logic rx_frame_end,
    input wire logic [2:0] frame_type,
    input wire logic has_dst_addr,
    input wire logic addr_match,
    input wire logic ack_request,
    input wire logic rx_buf_full,
    input wire logic tx_start,
    input wire logic tx_stop,
    input wire logic tx_out_ready,
    input wire logic tx_buf_valid,
    input wire logic [7:0] tx_buf_data,
    input wire logic tx_buf_last,
    input wire logic [7:0] tx_serial_data,
    input wire logic [15:0] sync_pattern,
    output logic channel_clear_flag,
    output logic [7:0] signal_strength_value,
    output logic frame_accept,
    output logic rx_crc_ok,
    output logic ack_start,
    output logic offset_filter_freeze,
    output logic modulation_reversed,
    output logic [4:0] correlator_threshold,
    output logic tx_out_valid,
    output logic [7:0] tx_out_data,
    output logic tx_buf_pop,
    output logic rx_buf_wr,
    output logic [7:0] rx_buf_wdata,
    output logic rx_pin_valid,
    output logic [7:0] rx_pin_data
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] ctrl_a_reg;
    logic [15:0] ctrl_b_reg;
    logic [7:0] thr_reg;
    logic [7:0] strength_reg;
    logic sclk_q_reg;
    logic [4:0] spi_cnt_reg;
    logic [15:0] spi_sh_reg;
    logic [15:0] spi_out_reg;
    logic [7:0] spi_addr_reg;

    wire sclk_rise = !spi_csn && spi_sclk && !sclk_q_reg;
    wire [15:0] spi_shift_w = {spi_sh_reg[14:0], spi_si};
    wire spi_addr_done = sclk_rise && spi_cnt_reg == MFC_SPI_ADDR_LAST;
    wire spi_data_done = sclk_rise && spi_cnt_reg == MFC_SPI_WORD_LAST;
    wire spi_wr = spi_data_done && spi_addr_reg[7:6] == 2'h0;
    wire wr_a = spi_wr && spi_addr_reg[5:0] == MFC_ADDR_CTRL_A;
    wire wr_b = spi_wr && spi_addr_reg[5:0] == MFC_ADDR_CTRL_B;
    wire wr_s = spi_wr && spi_addr_reg[5:0] == MFC_ADDR_STRENGTH;
    wire [5:0] rd_addr = spi_shift_w[5:0];
    wire rd_ok = !spi_shift_w[7];
    wire [15:0] rd_word =
        !rd_ok ? 16'h0000 :
        rd_addr == MFC_ADDR_CTRL_A ? ctrl_a_reg :
        rd_addr == MFC_ADDR_CTRL_B ? ctrl_b_reg :
        rd_addr == MFC_ADDR_STRENGTH ? {thr_reg, strength_reg} : 16'h0000;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_q_reg <= 1'b0;
            spi_cnt_reg <= 5'h00;
            spi_sh_reg <= 16'h0000;
            spi_addr_reg <= 8'h00;
            spi_out_reg <= 16'h0000;
            spi_so <= 1'b0;
        end
        else if (ce)
        begin
            sclk_q_reg <= spi_sclk;
            if (spi_csn)
                spi_cnt_reg <= 5'h00;
            else if (sclk_rise && spi_cnt_reg <= MFC_SPI_WORD_LAST)
                spi_cnt_reg <= spi_cnt_reg + 5'h01;
            if (sclk_rise)
                spi_sh_reg <= spi_shift_w;
            if (spi_addr_done)
            begin
                spi_addr_reg <= spi_shift_w[7:0];
                spi_so <= rd_word[15];
                spi_out_reg <= {rd_word[14:0], 1'b0};
            end
            else if (sclk_rise)
            begin
                spi_so <= spi_out_reg[15];
                spi_out_reg <= {spi_out_reg[14:0], 1'b0};
            end
        end
    end

    // reserved bits are dropped on write and read as zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_a_reg <= MFC_CTRL_A_RESET;
            ctrl_b_reg <= MFC_CTRL_B_RESET;
            thr_reg <= MFC_THR_RESET;
        end
        else if (ce)
        begin
            if (wr_a)
                ctrl_a_reg <= spi_shift_w & MFC_CTRL_A_MASK;
            if (wr_b)
                ctrl_b_reg <= spi_shift_w & MFC_CTRL_B_MASK;
            if (wr_s)
                thr_reg <= spi_shift_w[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire rsv_accept = ctrl_a_reg[MFC_A_RSV_FRAME];
    wire coord = ctrl_a_reg[MFC_A_COORD];
    wire adr_en = ctrl_a_reg[MFC_A_ADR_EN];
    wire [2:0] hyst = ctrl_a_reg[MFC_A_HYST_LSB +: 3];
    wire [1:0] sel = ctrl_a_reg[MFC_A_SEL_LSB +: 2];
    wire auto_checksum_enable = ctrl_a_reg[MFC_A_AUTO_CHECKSUM_ENABLE];
    wire auto_acknowledge_enable = ctrl_a_reg[MFC_A_AUTO_ACKNOWLEDGE_ENABLE];
    wire [3:0] pre_n = ctrl_a_reg[MFC_A_PRE_LSB +: 4];
    wire avg_mode = ctrl_b_reg[MFC_B_AVG];
    wire [1:0] tx_src = ctrl_b_reg[MFC_B_TXSRC_LSB +: 2];
    wire [1:0] rx_snk = ctrl_b_reg[MFC_B_RXSNK_LSB +: 2];
    assign correlator_threshold = ctrl_b_reg[MFC_B_CORR_LSB +: 5];

    ////////////////////////////////////////////////////////////////////////
    logic signed [10:0] acc_reg;
    logic [2:0] avg_cnt_reg;
    logic lvl_clear_reg;
    wire signed [10:0] acc_sum = acc_reg + {{3{rssi_sample[7]}}, rssi_sample};
    wire signed [9:0] s_val = {{2{strength_reg[7]}}, strength_reg};
    wire signed [9:0] t_val = {{2{thr_reg[7]}}, thr_reg};
    wire signed [9:0] t_low = t_val - $signed({7'h00, hyst});
    wire lvl_below = s_val < t_low;
    wire lvl_above = s_val >= t_val;
    wire lvl_next = lvl_below ? 1'b1 : lvl_above ? 1'b0 : lvl_clear_reg;
    // combined mode, reserved select reads busy
    wire clear_next =
        sel == MFC_SEL_LEVEL ? lvl_next :
        sel == MFC_SEL_RXDATA ? !rx_valid_data :
        sel == MFC_SEL_BOTH ? lvl_next && !rx_valid_data : 1'b0;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg <= 11'sh000;
            avg_cnt_reg <= 3'h0;
            strength_reg <= MFC_STRENGTH_INVALID;
        end
        else if (ce && !rx_on)
        begin
            acc_reg <= 11'sh000;
            avg_cnt_reg <= 3'h0;
            strength_reg <= MFC_STRENGTH_INVALID;
        end
        else if (ce && symbol_tick)
        begin
            avg_cnt_reg <= avg_cnt_reg + 3'h1;
            acc_reg <= avg_cnt_reg == MFC_AVG_LAST ? 11'sh000 : acc_sum;
            if (avg_cnt_reg == MFC_AVG_LAST)
                strength_reg <= acc_sum[10:3];
        end
    end
    assign signal_strength_value = strength_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lvl_clear_reg <= 1'b0;
            channel_clear_flag <= 1'b0;
        end
        else if (ce)
        begin
            lvl_clear_reg <= lvl_next;
            channel_clear_flag <= clear_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] rx_crc;
    logic ack_busy_reg;
    logic [3:0] ack_cnt_reg;
    mfc_crc16 u_rx_crc (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clear(rx_frame_start),
        .update(rx_byte_valid && auto_checksum_enable),
        .data(rx_byte),
        .crc(rx_crc)
    );
    wire crc_good = auto_checksum_enable && rx_crc == 16'h0000;
    // reserved types decided by the acceptance bit alone
    // no destination address decided by role
    wire accept_w =
        !adr_en ? 1'b1 :
        frame_type[2] ? rsv_accept :
        !has_dst_addr ? coord : addr_match;
    wire ack_arm = rx_frame_end && accept_w && ack_request && crc_good
        && auto_acknowledge_enable;
    wire ack_fire = ack_busy_reg && symbol_tick
        && ack_cnt_reg == MFC_ACK_SYMBOLS - 4'h1;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_accept <= 1'b0;
            rx_crc_ok <= 1'b0;
            ack_start <= 1'b0;
            ack_busy_reg <= 1'b0;
            ack_cnt_reg <= 4'h0;
        end
        else if (ce)
        begin
            frame_accept <= rx_frame_end && accept_w;
            rx_crc_ok <= rx_frame_end && crc_good;
            ack_start <= ack_fire;
            if (ack_arm)
            begin
                ack_busy_reg <= 1'b1;
                ack_cnt_reg <= 4'h0;
            end
            else if (ack_fire)
                ack_busy_reg <= 1'b0;
            else if (ack_busy_reg && symbol_tick)
                ack_cnt_reg <= ack_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            offset_filter_freeze <= 1'b0;
            modulation_reversed <= 1'b0;
        end
        else if (ce)
        begin
            offset_filter_freeze <= !avg_mode && preamble_match;
            modulation_reversed <= ctrl_b_reg[MFC_B_MODUL];
        end
    end

    // buffer or pins, reserved sink drops data
    wire snk_buf = rx_byte_valid && ((rx_snk == MFC_SNK_BUFFER && !rx_buf_full)
        || rx_snk == MFC_SNK_LOOP);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_buf_wr <= 1'b0;
            rx_buf_wdata <= 8'h00;
            rx_pin_valid <= 1'b0;
            rx_pin_data <= 8'h00;
        end
        else if (ce)
        begin
            rx_buf_wr <= snk_buf;
            rx_pin_valid <= rx_byte_valid && rx_snk == MFC_SNK_PINS;
            if (rx_byte_valid)
            begin
                rx_buf_wdata <= rx_byte;
                rx_pin_data <= rx_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    mfc_tx_state_t tx_state_reg;
    mfc_tx_state_t tx_state_next;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_cnt_next;
    logic [7:0] tx_byte_next;
    logic tx_emit;
    logic tx_take;
    logic [15:0] tx_crc;
    wire tx_free = !tx_out_valid || tx_out_ready;
    wire tx_go = tx_state_reg != MFC_TX_IDLE && !tx_out_valid;
    wire [7:0] data_src =
        tx_src == MFC_SRC_SERIAL ? tx_serial_data :
        tx_src == MFC_SRC_PRBS ? tx_crc[7:0] : tx_buf_data;
    wire [7:0] crc_feed = tx_src == MFC_SRC_PRBS ? MFC_PRBS_FEED : data_src;
    wire tx_data_upd = tx_go && tx_state_reg == MFC_TX_DATA && tx_emit;

    mfc_crc16 u_tx_crc (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .clear(tx_start && tx_state_reg == MFC_TX_IDLE),
        .update(tx_data_upd),
        .data(crc_feed),
        .crc(tx_crc)
    );

    always_comb
    begin
        tx_state_next = tx_state_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_byte_next = 8'h00;
        tx_emit = 1'b0;
        tx_take = 1'b0;
        case (tx_state_reg)
            MFC_TX_IDLE:
            begin
                tx_cnt_next = 4'h0;
                if (tx_start)
                    tx_state_next = MFC_TX_PRE;
            end
            MFC_TX_PRE:
            begin
                tx_emit = 1'b1;
                tx_cnt_next = tx_cnt_reg + 4'h1;
                if (tx_cnt_reg == pre_n)
                begin
                    tx_cnt_next = 4'h0;
                    tx_state_next = MFC_TX_SYNC;
                end
            end
            MFC_TX_SYNC:
            begin
                tx_emit = 1'b1;
                tx_byte_next = tx_cnt_reg[0] ? sync_pattern[15:8]
                    : sync_pattern[7:0];
                tx_cnt_next = 4'h1;
                if (tx_cnt_reg[0])
                    tx_state_next = MFC_TX_DATA;
            end
            MFC_TX_DATA:
            begin
                // looping source pops regardless of underflow
                tx_emit = tx_src != MFC_SRC_BUFFER || tx_buf_valid;
                tx_take = tx_emit && (tx_src == MFC_SRC_BUFFER
                    || tx_src == MFC_SRC_LOOP);
                tx_byte_next = data_src;
                if (tx_emit && tx_src == MFC_SRC_BUFFER && tx_buf_last)
                    tx_state_next = auto_checksum_enable ? MFC_TX_CRC_LO : MFC_TX_IDLE;
            end
            MFC_TX_CRC_LO:
            begin
                tx_emit = 1'b1;
                tx_byte_next = tx_crc[7:0];
                tx_state_next = MFC_TX_CRC_HI;
            end
            MFC_TX_CRC_HI:
            begin
                tx_emit = 1'b1;
                tx_byte_next = tx_crc[15:8];
                tx_state_next = MFC_TX_IDLE;
            end
            default:
                tx_state_next = MFC_TX_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state_reg <= MFC_TX_IDLE;
            tx_cnt_reg <= 4'h0;
            tx_out_valid <= 1'b0;
            tx_out_data <= 8'h00;
            tx_buf_pop <= 1'b0;
        end
        else if (ce)
        begin
            tx_buf_pop <= tx_go && tx_take;
            if (tx_stop)
                tx_state_reg <= MFC_TX_IDLE;
            else if (tx_go || tx_state_reg == MFC_TX_IDLE)
            begin
                tx_state_reg <= tx_state_next;
                tx_cnt_reg <= tx_cnt_next;
            end
            if (tx_go && tx_emit)
            begin
                tx_out_valid <= 1'b1;
                tx_out_data <= tx_byte_next;
            end
            else if (tx_free)
                tx_out_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_RSV_REJECT: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && rx_frame_end && adr_en && frame_type[2] && !rsv_accept
        |=> !frame_accept)
        else $error("reserved frame accepted");
    AST_RSV_ACCEPT: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && rx_frame_end && adr_en && frame_type[2] && rsv_accept
        |=> frame_accept)
        else $error("reserved frame rejected");
    AST_NO_FILTER: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && rx_frame_end && !adr_en |=> frame_accept)
        else $error("frame dropped with filter off");
    AST_COORD: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && rx_frame_end && adr_en && !frame_type[2] && !has_dst_addr
        |=> frame_accept == $past(coord))
        else $error("coordinator role ignored");
    AST_LEVEL_BUSY: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && sel == MFC_SEL_LEVEL && lvl_above |=> !channel_clear_flag)
        else $error("clear flag high above threshold");
    AST_DATA_MODE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && sel == MFC_SEL_RXDATA
        |=> channel_clear_flag == !$past(rx_valid_data))
        else $error("data mode clear flag wrong");
    AST_ACK_DELAY: assert property (
        @(posedge clk) disable iff (!rst_n)
        ack_start |-> $past(ack_cnt_reg) == 4'hb && $past(symbol_tick))
        else $error("acknowledge not twelve symbols");
    AST_PREAMBLE_END: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && !tx_stop && tx_go && tx_state_reg == MFC_TX_PRE
        && tx_cnt_reg == pre_n |=> tx_state_reg == MFC_TX_SYNC && tx_out_valid
        && tx_out_data == 8'h00)
        else $error("preamble length wrong");
    AST_FREEZE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce |=> offset_filter_freeze == (!$past(avg_mode)
        && $past(preamble_match)))
        else $error("offset filter freeze wrong");
    AST_LOOP_POP: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && tx_go && tx_state_reg == MFC_TX_DATA && tx_src == MFC_SRC_LOOP
        |=> tx_buf_pop)
        else $error("looping source did not pop");
    AST_STRENGTH_OFF: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && !rx_on |=> signal_strength_value == MFC_STRENGTH_INVALID)
        else $error("strength valid while receiver off");
endmodule : mfc_modem_frame_control

/* File: bench/mfc_peer_model.sv */
// air-side modulator model with random stalls
`timescale 1ns/1ps
module mfc_peer_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic tx_out_ready
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tx_out_ready <= 1'b0;
        else
            tx_out_ready <= 1'($urandom_range(0, 1));
    end
endmodule : mfc_peer_model

/* File: bench/modem_frame_control_tb.sv */
// self-checking bench of the modem frame control block
`timescale 1ns/1ps
module modem_frame_control_tb;
    import mfc_pkg::*;
    logic clk, rst_n, ce, spi_csn, spi_sclk, spi_si, spi_so;
    logic symbol_tick, rx_on, rx_valid_data, preamble_match;
    logic rx_frame_start, rx_byte_valid, rx_frame_end, has_dst_addr;
    logic addr_match, ack_request, rx_buf_full, tx_start, tx_stop;
    logic tx_out_ready, tx_buf_valid, tx_buf_last, tx_out_valid;
    logic channel_clear_flag, frame_accept, rx_crc_ok, ack_start;
    logic offset_filter_freeze, modulation_reversed, tx_buf_pop;
    logic rx_buf_wr, rx_pin_valid;
    logic [2:0] frame_type;
    logic [4:0] correlator_threshold;
    logic [7:0] rssi_sample, rx_byte, tx_buf_data, tx_serial_data;
    logic [7:0] signal_strength_value, tx_out_data, rx_buf_wdata;
    logic [7:0] rx_pin_data, r, q, e[8];
    logic [15:0] sync_pattern, rd, c;
    logic [7:0] got[$];
    int failures, samples_checked, s;
    mfc_modem_frame_control dut (.*);
    mfc_peer_model peer (.*);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (tx_out_valid && tx_out_ready) got.push_back(tx_out_data);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic spi(input logic [7:0] a, input logic [15:0] w);
        logic [23:0] f;
        f = {a, w};
        spi_csn = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            spi_si = f[i];
            spi_sclk = 1'b0;
            repeat (2) @(negedge clk);
            if (i < 16) rd = {rd[14:0], spi_so};
            spi_sclk = 1'b1;
            repeat (2) @(negedge clk);
        end
        spi_csn = 1'b1;
        @(negedge clk);
    endtask : spi
    function automatic logic acc_f(input logic [7:0] v);
        if (!v[0]) return 1'b1;
        if (v[7]) return v[2];
        return v[4] ? v[3] : v[1];
    endfunction : acc_f
    function automatic logic [15:0] crc_f(input logic [7:0] d);
        logic [15:0] s;
        s = MFC_CRC_INIT;
        for (int i = 0; i < 8; i++)
            s = (s[0] ^ d[i]) ? (s >> 1) ^ MFC_CRC_POLY : s >> 1;
        return s;
    endfunction : crc_f
    task automatic put(input logic [7:0] b);
        logic wr_exp;
        wr_exp = q[1:0] == 2'h2 || (q[1:0] == 2'h0 && !q[2]);
        {rx_byte, rx_byte_valid} = {b, 1'b1};
        @(negedge clk);
        rx_byte_valid = 1'b0;
        chk(rx_buf_wr, wr_exp);
        chk(rx_pin_valid, q[1:0] == 2'h1);
        chk(rx_buf_wdata, b);
        chk(rx_pin_data, b);
        @(negedge clk);
    endtask : put
    task automatic conclude;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, spi_sclk, spi_si, rx_on, rx_valid_data, symbol_tick} = '0;
        {preamble_match, rx_frame_start, rx_byte_valid, rx_frame_end} = '0;
        {has_dst_addr, addr_match, ack_request, rx_buf_full} = '0;
        {tx_start, tx_stop, tx_buf_valid, tx_buf_last} = '0;
        {frame_type, rssi_sample, rx_byte, tx_serial_data} = '0;
        {tx_buf_data, sync_pattern, rd} = '0;
        {ce, spi_csn} = 2'b11;
        failures = 0;
        samples_checked = 0;
        void'($urandom(32'h535c));
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        spi(8'h51, 16'h0);
        chk(rd, 16'h0ae2);
        spi(8'h53, 16'h0);
        chk(rd, 16'he080);
        spi(8'h54, 16'h0);
        chk(rd, 16'h0000);
        chk(channel_clear_flag, 1);
        rx_valid_data = 1'b1;
        repeat (2) @(negedge clk);
        chk(channel_clear_flag, 0);
        spi(8'h11, 16'h0a62);
        chk(channel_clear_flag, 1);
        spi(8'h13, 16'h8000);
        chk(channel_clear_flag, 0);
        spi(8'h11, 16'h0aa2);
        chk(channel_clear_flag, 0);
        rx_valid_data = 1'b0;
        repeat (2) @(negedge clk);
        chk(channel_clear_flag, 1);
        rx_on = 1'b1;
        s = 0;
        repeat (8)
        begin
            rssi_sample = 8'($urandom);
            s += $signed(rssi_sample);
            symbol_tick = 1'b1;
            @(negedge clk);
            symbol_tick = 1'b0;
            @(negedge clk);
        end
        chk(signal_strength_value, 8'(s >>> 3));
        rx_on = 1'b0;
        @(negedge clk);
        chk(signal_strength_value, 8'h80);
        spi(8'h12, 16'h0510);
        spi(8'h52, 16'h0);
        chk(rd, 16'h0510);
        chk(correlator_threshold, 20);
        chk(modulation_reversed, 1);
        repeat (16)
        begin
            r = 8'($urandom);
            q = 8'($urandom);
            spi(8'h11, {2'b00, r[2:0], 11'h2f2});
            spi(8'h12, {14'h0144, q[1:0]});
            {frame_type, has_dst_addr, addr_match} = r[7:3];
            {ack_request, rx_buf_full} = {q[4], q[2]};
            c = crc_f(r);
            rx_frame_start = 1'b1;
            @(negedge clk);
            rx_frame_start = 1'b0;
            put(r);
            put(c[7:0]);
            put(c[15:8] ^ {7'h00, q[3]});
            rx_frame_end = 1'b1;
            @(negedge clk);
            rx_frame_end = 1'b0;
            chk(frame_accept, acc_f(r));
            chk(rx_crc_ok, !q[3]);
            for (int i = 0; i < 12; i++)
            begin
                symbol_tick = 1'b1;
                @(negedge clk);
                symbol_tick = 1'b0;
                chk(ack_start, i == 11 && acc_f(r) && q[4] && !q[3]);
                @(negedge clk);
            end
        end
        r = 8'($urandom);
        sync_pattern = 16'($urandom);
        c = crc_f(r);
        e = '{0, 0, 0, sync_pattern[7:0], sync_pattern[15:8], r, c[7:0],
              c[15:8]};
        {tx_buf_data, tx_buf_valid, tx_buf_last, tx_start} = {r, 3'b111};
        @(negedge clk);
        tx_start = 1'b0;
        wait (tx_buf_pop);
        @(negedge clk);
        tx_buf_valid = 1'b0;
        repeat (150) @(negedge clk);
        chk(got.size(), 8);
        for (int i = 0; i < got.size(); i++)
            chk(got[i], e[i]);
        got.delete();
        spi(8'h12, 16'h0518);
        tx_start = 1'b1;
        @(negedge clk);
        tx_start = 1'b0;
        repeat (100) @(negedge clk);
        tx_stop = 1'b1;
        @(negedge clk);
        tx_stop = 1'b0;
        repeat (30) @(negedge clk);
        chk(got.size() > 8, 1);
        for (int i = 0; i < got.size(); i++)
            chk(got[i], i < 5 ? e[i] : r);
        conclude();
    end
    initial
    begin
        #300000;
        failures++;
        conclude();
    end
endmodule : modem_frame_control_tb
